// [hw/pcr_dev.sv]
// Flash sequencer end: page compare, auto page rewrite and status read
//
// Overview of operation
// - 264-byte compare: 60h, 5 dc, page, 9 dc
// - 256-byte compare: 60h, 6 dc, page, 8 dc
// - Host holds select low while clocking bytes
// - Compare starts at select rise, busy meanwhile
// - Compare result to byte one bit 6
// - 264-byte rewrite: 58h, 5 dc, page, 9 dc
// - 256-byte rewrite: 58h, 6 dc, page, 8 dc
// - Rewrite at select rise, busy throughout duration
// - Host refreshes pages within 50,000 sector cycles
// - Data after 58h address means read-modify-write
// - D7h streams status bytes, first byte first
// - Status bytes repeat while select stays low
// - Status read accepted even while busy
// - Status live; ready bit resampled per byte
// - Select rise ends read, output released
// - Ready bit: 0 busy, 1 idle
// - Byte one bits 5:2 fixed capacity code
// - Byte one bit 1 shows protection
// - Byte one bit 0 shows page size
// - Byte two bit 5 shows program fault
// - Byte two bit 3 shows lockdown allowed
// - Byte two reserved bits read zero
// - Fault flag updated per operation, not aborts
`timescale 1ns/1ps
module pcr_dev #(
    parameter int unsigned COMPARE_CYC = pcr_pkg::COMPARE_CYC_DEF,
    parameter int unsigned REWRITE_CYC = pcr_pkg::REWRITE_CYC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    pcr_spi_if.dev spi,
    input wire logic page_size_bin,
    input wire logic protect_en,
    input wire logic lockdown_frozen,
    input wire logic page_mismatch,
    input wire logic array_busy,
    input wire logic prog_done,
    input wire logic prog_fault,
    input wire logic prog_abort,
    output logic [9:0] cmd_page,
    output logic compare_start,
    output logic rewrite_start,
    output logic rmw_start,
    output logic busy
);
    typedef enum logic [1:0] {
        PCR_OP_IDLE = 2'b00,
        PCR_OP_COMPARE = 2'b01,
        PCR_OP_REWRITE = 2'b10
    } pcr_op_e;

    typedef struct packed {
        logic cs_m;
        logic cs_s;
        logic cs_d;
        logic sck_m;
        logic sck_s;
        logic sck_d;
        logic si_m;
        logic si_s;
        logic [2:0] bitc;
        logic [2:0] bytec;
        logic [7:0] opc;
        logic [23:0] addr;
        logic stat_mode;
        logic [3:0] sidx;
        logic [7:0] obyte;
        logic so;
        pcr_op_e op;
        logic [31:0] busy_cnt;
        logic comp;
        logic fault;
        logic [9:0] page;
        logic cmp_go;
        logic rw_go;
        logic rmw_go;
    } pcr_dev_s;

    pcr_dev_s r;
    pcr_dev_s n;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic busy_now;
    logic [7:0] in_byte;
    logic [7:0] st1;
    logic [7:0] st2;
    logic [7:0] st_pick;
    logic [9:0] page_sel;

    always_comb
    begin
        sck_rise = r.sck_s & ~r.sck_d;
        sck_fall = ~r.sck_s & r.sck_d;
        cs_rise = r.cs_s & ~r.cs_d;
        busy_now = (r.busy_cnt != 32'h0) | array_busy;
        in_byte = {r.opc[6:0], r.si_s};
        // Status bytes built live
        st1 = 8'h00;
        st1[pcr_pkg::ST_READY_BIT] = ~busy_now;
        st1[pcr_pkg::ST1_COMP_BIT] = r.comp;
        st1[pcr_pkg::ST1_DENS_LSB +: 4] = pcr_pkg::DENSITY_CODE;
        st1[pcr_pkg::ST1_PROT_BIT] = protect_en;
        st1[pcr_pkg::ST1_SIZE_BIT] = page_size_bin;
        st2 = 8'h00;
        st2[pcr_pkg::ST_READY_BIT] = ~busy_now;
        st2[pcr_pkg::ST2_FAULT_BIT] = r.fault;
        st2[pcr_pkg::ST2_LOCK_BIT] = ~lockdown_frozen;
        st_pick = r.sidx[3] ? st2 : st1;
        // Page field position by page size
        page_sel = page_size_bin ? r.addr[17:8] : r.addr[18:9];

        n = r;
        n.cs_m = spi.cs_n;
        n.cs_s = r.cs_m;
        n.cs_d = r.cs_s;
        n.sck_m = spi.sck;
        n.sck_s = r.sck_m;
        n.sck_d = r.sck_s;
        n.si_m = spi.si;
        n.si_s = r.si_m;
        n.cmp_go = 1'b0;
        n.rw_go = 1'b0;
        n.rmw_go = 1'b0;

        // Self-timed operation countdown
        if (r.busy_cnt != 32'h0)
        begin
            n.busy_cnt = r.busy_cnt - 32'h1;
            if (r.busy_cnt == 32'h1)
            begin
                case (r.op)
                    PCR_OP_COMPARE: n.comp = page_mismatch;
                    PCR_OP_REWRITE:
                    begin
                        if (!prog_abort)
                        begin
                            n.fault = prog_fault;
                        end
                    end
                    default: n.comp = r.comp;
                endcase
                n.op = PCR_OP_IDLE;
            end
        end

        // Outside erase or program result
        if (prog_done && !prog_abort)
        begin
            n.fault = prog_fault;
        end

        // Shift in on rising serial clock
        if (!r.cs_s && sck_rise)
        begin
            n.bitc = r.bitc + 3'h1;
            if (r.bytec == 3'h0)
            begin
                n.opc = in_byte;
            end
            else if (r.bytec < pcr_pkg::ADDR_BYTES_END)
            begin
                n.addr = {r.addr[22:0], r.si_s};
            end
            if (r.bitc == 3'h7)
            begin
                if (r.bytec != pcr_pkg::DATA_SEEN)
                begin
                    n.bytec = r.bytec + 3'h1;
                end
                if (r.bytec == 3'h0 && in_byte == pcr_pkg::OP_STATUS)
                begin
                    n.stat_mode = 1'b1;
                    n.sidx = 4'h0;
                end
            end
        end

        // Shift out on falling serial clock
        if (!r.cs_s && sck_fall && r.stat_mode)
        begin
            if (r.sidx[2:0] == 3'h0)
            begin
                n.so = st_pick[7];
                n.obyte = {st_pick[6:0], 1'b0};
            end
            else
            begin
                n.so = r.obyte[7];
                n.obyte = {r.obyte[6:0], 1'b0};
            end
            n.sidx = r.sidx + 4'h1;
        end

        // Frame end
        if (cs_rise)
        begin
            n.stat_mode = 1'b0;
            n.bitc = 3'h0;
            n.bytec = 3'h0;
            n.opc = 8'h00;
            if (!busy_now && r.bitc == 3'h0)
            begin
                if (r.bytec == pcr_pkg::ADDR_BYTES_END && r.opc == pcr_pkg::OP_COMPARE)
                begin
                    n.op = PCR_OP_COMPARE;
                    n.busy_cnt = COMPARE_CYC;
                    n.page = page_sel;
                    n.cmp_go = 1'b1;
                end
                else if (r.bytec == pcr_pkg::ADDR_BYTES_END && r.opc == pcr_pkg::OP_REWRITE)
                begin
                    n.op = PCR_OP_REWRITE;
                    n.busy_cnt = REWRITE_CYC;
                    n.page = page_sel;
                    n.rw_go = 1'b1;
                end
                else if (r.bytec == pcr_pkg::DATA_SEEN && r.opc == pcr_pkg::OP_REWRITE)
                begin
                    n.page = page_sel;
                    n.rmw_go = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.cs_m <= 1'b1;
            r.cs_s <= 1'b1;
            r.cs_d <= 1'b1;
            r.op <= PCR_OP_IDLE;
            r.comp <= pcr_pkg::RST_COMP;
            r.fault <= pcr_pkg::RST_FAULT;
        end
        else
        begin
            r <= n;
        end
    end

    assign spi.so = r.so;
    assign spi.so_oe = r.stat_mode & ~r.cs_s;
    assign cmd_page = r.page;
    assign compare_start = r.cmp_go;
    assign rewrite_start = r.rw_go;
    assign rmw_start = r.rmw_go;
    assign busy = busy_now;
endmodule : pcr_dev

// [hw/pcr_host.sv]
// Host controller end: APB registers driving the serial link
`timescale 1ns/1ps
module pcr_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    pcr_spi_if.host spi
);
    typedef enum logic [1:0] {
        PCR_H_IDLE = 2'b00,
        PCR_H_RUN = 2'b01,
        PCR_H_END = 2'b10
    } pcr_hst_e;

    typedef struct packed {
        pcr_hst_e st;
        logic [9:0] page;
        logic [7:0] count;
        logic [31:0] tx;
        logic [15:0] rx;
        logic [15:0] result;
        logic [11:0] bits;
        logic [11:0] total;
        logic [3:0] div;
        logic cs_n;
        logic sck;
        logic si;
        logic so_m;
        logic so_s;
        logic [31:0] rdata;
    } pcr_host_s;

    pcr_host_s r;
    pcr_host_s n;
    logic access;
    logic mapped;
    logic [23:0] addr_bytes;
    logic [7:0] opc_w;

    always_comb
    begin
        access = psel & penable;
        mapped = (paddr == pcr_pkg::REG_CMD) | (paddr == pcr_pkg::REG_PAGE) |
            (paddr == pcr_pkg::REG_COUNT) | (paddr == pcr_pkg::REG_RESULT);
        opc_w = pwdata[7:0];
        // Page placed by size: 6/8 or 5/9 don't-care bits
        addr_bytes = pwdata[pcr_pkg::CMD_SIZE_BIT] ? {6'h00, r.page, 8'h00} :
            {5'h00, r.page, 9'h000};
        n = r;
        n.so_m = spi.so_line;
        n.so_s = r.so_m;

        // Register access
        if (access && pwrite)
        begin
            if (paddr == pcr_pkg::REG_PAGE)
            begin
                n.page = pwdata[9:0];
            end
            if (paddr == pcr_pkg::REG_COUNT)
            begin
                n.count = pwdata[7:0];
            end
            if (paddr == pcr_pkg::REG_CMD && r.st == PCR_H_IDLE)
            begin
                n.tx = {opc_w, addr_bytes};
                n.total = (opc_w == pcr_pkg::OP_STATUS) ?
                    pcr_pkg::OPCODE_BITS + {1'b0, r.count, 3'h0} : pcr_pkg::CMD_BITS;
                n.bits = 12'h000;
                n.div = 4'h0;
                n.cs_n = 1'b0;
                n.sck = 1'b0;
                n.si = opc_w[7];
                n.st = PCR_H_RUN;
            end
        end
        n.rdata = 32'h0;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                pcr_pkg::REG_PAGE: n.rdata = {22'h0, r.page};
                pcr_pkg::REG_COUNT: n.rdata = {24'h0, r.count};
                pcr_pkg::REG_RESULT: n.rdata = {15'h0, r.st != PCR_H_IDLE, r.result};
                default: n.rdata = 32'h0;
            endcase
        end

        // Serial clock divider and shifter
        case (r.st)
            PCR_H_RUN:
            begin
                n.div = r.div + 4'h1;
                if (r.div == pcr_pkg::SCK_HALF_CYC - 4'h1)
                begin
                    n.div = 4'h0;
                    if (!r.sck)
                    begin
                        n.sck = 1'b1;
                    end
                    else
                    begin
                        n.sck = 1'b0;
                        n.rx = {r.rx[14:0], r.so_s};
                        n.tx = {r.tx[30:0], 1'b0};
                        n.si = r.tx[30];
                        n.bits = r.bits + 12'h001;
                        if (r.bits + 12'h001 == r.total)
                        begin
                            n.st = PCR_H_END;
                        end
                    end
                end
            end
            PCR_H_END:
            begin
                n.div = r.div + 4'h1;
                if (r.div == pcr_pkg::SCK_HALF_CYC - 4'h1)
                begin
                    n.div = 4'h0;
                    n.cs_n = 1'b1;
                    n.si = 1'b0;
                    n.result = r.rx;
                    n.st = PCR_H_IDLE;
                end
            end
            default: n.div = 4'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
            r.st <= PCR_H_IDLE;
            r.cs_n <= 1'b1;
            r.so_m <= 1'b1;
            r.so_s <= 1'b1;
            r.page <= pcr_pkg::RST_PAGE;
            r.count <= pcr_pkg::RST_COUNT;
        end
        else
        begin
            r <= n;
        end
    end

    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign spi.cs_n = r.cs_n;
    assign spi.sck = r.sck;
    assign spi.si = r.si;
endmodule : pcr_host

// [hw/pcr_pkg.sv]
// Shared constants for the page compare, rewrite and status serial-flash link
package pcr_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Opcodes
    localparam logic [7:0] OP_COMPARE = 8'h60;
    localparam logic [7:0] OP_REWRITE = 8'h58;
    localparam logic [7:0] OP_STATUS = 8'hd7;
    // Command framing
    localparam logic [2:0] ADDR_BYTES_END = 3'h4;
    localparam logic [2:0] DATA_SEEN = 3'h5;
    localparam logic [11:0] CMD_BITS = 12'h020;
    localparam logic [11:0] OPCODE_BITS = 12'h008;
    // Status byte one fields
    localparam int unsigned ST_READY_BIT = 7;
    localparam int unsigned ST1_COMP_BIT = 6;
    localparam int unsigned ST1_DENS_LSB = 2;
    localparam int unsigned ST1_PROT_BIT = 1;
    localparam int unsigned ST1_SIZE_BIT = 0;
    // Status byte two fields
    localparam int unsigned ST2_FAULT_BIT = 5;
    localparam int unsigned ST2_LOCK_BIT = 3;
    // Capacity code, arbitrary value
    localparam logic [3:0] DENSITY_CODE = 4'h9;
    // Reset values
    localparam logic RST_COMP = 1'b0;
    localparam logic RST_FAULT = 1'b0;
    // Self-timed durations, plain defaults
    localparam int unsigned COMPARE_DURATION_NS = 20000;
    localparam int unsigned REWRITE_DURATION_NS = 2000000;
    localparam int unsigned COMPARE_CYC_DEF = (COMPARE_DURATION_NS / CLK_PERIOD_NS) > 0 ?
        (COMPARE_DURATION_NS / CLK_PERIOD_NS) : 1;
    localparam int unsigned REWRITE_CYC_DEF = (REWRITE_DURATION_NS / CLK_PERIOD_NS) > 0 ?
        (REWRITE_DURATION_NS / CLK_PERIOD_NS) : 1;
    // Host serial clock: half period in pclk cycles
    localparam logic [3:0] SCK_HALF_CYC = 4'h8;
    // Host APB register offsets
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_PAGE = 12'h004;
    localparam logic [11:0] REG_COUNT = 12'h008;
    localparam logic [11:0] REG_RESULT = 12'h00c;
    localparam int unsigned CMD_SIZE_BIT = 8;
    localparam int unsigned RESULT_BUSY_BIT = 16;
    localparam logic [9:0] RST_PAGE = 10'h000;
    localparam logic [7:0] RST_COUNT = 8'h02;
endpackage : pcr_pkg

// [hw/pcr_spi_if.sv]
// Serial link between host controller and flash sequencer
`timescale 1ns/1ps
interface pcr_spi_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;
    // Released line reads high
    assign so_line = so_oe ? so : 1'b1;
    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (output cs_n, output sck, output si, input so_line);
endinterface : pcr_spi_if

// [verification/page_compare_rewrite_status_tb.sv]
// Testbench joining host controller and flash sequencer ends
`timescale 1ns/1ps
module page_compare_rewrite_status_tb;
    localparam int CMP_CYC = 1000;
    localparam int RW_CYC = 1200;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic page_size_bin, protect_en, lockdown_frozen, page_mismatch;
    logic array_busy, prog_done, prog_fault, prog_abort, e;
    logic [9:0] cmd_page;
    logic compare_start, rewrite_start, rmw_start, busy;
    logic [15:0] e16;
    logic [31:0] si_sh;
    int si_n, n_start, n_rmw, span, run, err_count, n_compared, s0;
    pcr_spi_if spi();
    pcr_dev #(.COMPARE_CYC(CMP_CYC), .REWRITE_CYC(RW_CYC)) pcr_dev_i (.pclk(pclk),
        .presetn(presetn), .spi(spi), .page_size_bin(page_size_bin), .protect_en(protect_en),
        .lockdown_frozen(lockdown_frozen), .page_mismatch(page_mismatch),
        .array_busy(array_busy), .prog_done(prog_done), .prog_fault(prog_fault),
        .prog_abort(prog_abort), .cmd_page(cmd_page), .compare_start(compare_start),
        .rewrite_start(rewrite_start), .rmw_start(rmw_start), .busy(busy));
    pcr_host pcr_host_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spi(spi));
    pcr_properties pcr_properties_i (.pclk(pclk), .presetn(presetn), .cs_n(spi.cs_n),
        .sck(spi.sck), .si(spi.si), .so(spi.so), .so_oe(spi.so_oe), .so_line(spi.so_line));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // Wire watcher: bits shifted in per frame
    always @(posedge spi.sck or negedge spi.cs_n)
    begin
        if (!spi.sck)
            si_n <= 0;
        else
        begin
            si_sh <= {si_sh[30:0], spi.si};
            si_n <= si_n + 1;
        end
    end

    // Start pulses and length of the last busy span
    always @(posedge pclk)
    begin
        if (compare_start || rewrite_start)
            n_start <= n_start + 1;
        if (rmw_start)
            n_rmw <= n_rmw + 1;
        if (busy)
            run <= run + 1;
        else if (run != 0)
        begin
            span <= run;
            run <= 0;
        end
    end

    function automatic logic [15:0] exp_st(input logic rdy, input logic cmp, input logic flt);
        exp_st = {rdy, cmp, pcr_pkg::DENSITY_CODE, protect_en, page_size_bin,
            rdy, 1'b0, flt, 1'b0, !lockdown_frozen, 3'b000};
    endfunction : exp_st

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(a, 1'b1, d, rd, er);
    endtask : wr_reg

    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(posedge pclk);
        do
        begin
            apb(pcr_pkg::REG_RESULT, 1'b0, 32'h0, v, e);
            n++;
        end
        while (v[16] !== 1'b0 && n < 400);
        check("host idle", 32'h0, {31'h0, v[16]});
    endtask : wait_idle

    task automatic status(input logic [7:0] cnt, input logic [15:0] exp);
        wr_reg(pcr_pkg::REG_COUNT, {24'h0, cnt});
        wr_reg(pcr_pkg::REG_CMD, {24'h0, pcr_pkg::OP_STATUS});
        wait_idle();
        check("status opcode", {24'h0, pcr_pkg::OP_STATUS}, {24'h0, si_sh[8 * cnt + 7 -: 8]});
        check("status frame bits", 8 + 8 * cnt, si_n);
        apb(pcr_pkg::REG_RESULT, 1'b0, 32'h0, v, e);
        check("status word", {16'h0, exp}, {16'h0, v[15:0]});
    endtask : status

    // fl = {compare before, compare after, fault before, fault after}
    task automatic op(input logic [7:0] opc, input logic sz, input logic [9:0] pg,
        input logic [3:0] fl, input int cyc);
        int n;
        s0 = n_start;
        page_size_bin <= sz;
        wr_reg(pcr_pkg::REG_PAGE, {22'h0, pg});
        wr_reg(pcr_pkg::REG_CMD, {23'h0, sz, opc});
        wait_idle();
        check("command opcode", {24'h0, opc}, {24'h0, si_sh[31:24]});
        check("page field", {22'h0, pg}, {22'h0, sz ? si_sh[17:8] : si_sh[18:9]});
        check("command bits", 32, si_n);
        repeat (8) @(posedge pclk);
        check("start pulses", s0 + 1, n_start);
        check("started page", {22'h0, pg}, {22'h0, cmd_page});
        check("rmw pulses", 0, n_rmw);
        status(8'h02, exp_st(1'b0, fl[3], fl[1]));
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        check("busy span", cyc, span);
        status(8'h02, exp_st(1'b1, fl[2], fl[0]));
    endtask : op

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {page_size_bin, protect_en, lockdown_frozen, page_mismatch} = 4'h0;
        {array_busy, prog_done, prog_fault, prog_abort} = 4'h0;
        void'($urandom(32'h7b2c4085));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(pcr_pkg::REG_PAGE, 1'b0, 32'h0, v, e);
        check("page reset", {22'h0, pcr_pkg::RST_PAGE}, v);
        apb(pcr_pkg::REG_COUNT, 1'b0, 32'h0, v, e);
        check("count reset", {24'h0, pcr_pkg::RST_COUNT}, v);
        apb(12'h010, 1'b0, 32'h0, v, e);
        check("unmapped error", 32'h1, {31'h0, e});
        for (int i = 0; i < 4; i++)
        begin
            protect_en <= 1'($urandom);
            page_size_bin <= 1'($urandom);
            lockdown_frozen <= 1'($urandom);
            array_busy <= (i == 3);
            @(posedge pclk);
            e16 = exp_st(i != 3, 1'b0, 1'b0);
            status(i[0] ? 8'h02 : 8'h03, i[0] ? e16 : {e16[7:0], e16[15:8]});
        end
        s0 = n_start;
        wr_reg(pcr_pkg::REG_CMD, {24'h0, pcr_pkg::OP_COMPARE});
        wait_idle();
        repeat (8) @(posedge pclk);
        check("refused start", s0, n_start);
        array_busy <= 1'b0;
        page_mismatch <= 1'b1;
        op(pcr_pkg::OP_COMPARE, 1'b1, 10'($urandom), 4'b0100, CMP_CYC);
        page_mismatch <= 1'b0;
        op(pcr_pkg::OP_COMPARE, 1'b0, 10'h3ff, 4'b1000, CMP_CYC);
        prog_fault <= 1'b1;
        op(pcr_pkg::OP_REWRITE, 1'b0, 10'h000, 4'b0001, RW_CYC);
        prog_fault <= 1'b0;
        prog_abort <= 1'b1;
        op(pcr_pkg::OP_REWRITE, 1'b1, 10'($urandom), 4'b0011, RW_CYC);
        prog_abort <= 1'b0;
        @(posedge pclk);
        prog_done <= 1'b1;
        @(posedge pclk);
        prog_done <= 1'b0;
        repeat (4) @(posedge pclk);
        status(8'h02, exp_st(1'b1, 1'b0, 1'b0));
        give_verdict();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge pclk);
        err_count++;
        give_verdict();
    end
endmodule : page_compare_rewrite_status_tb

// [verification/pcr_properties.sv]
// Serial link assertions for the flash sequencer link
`timescale 1ns/1ps
module pcr_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_sck_in_frame: assert property ($rose(sck) |-> !cs_n)
        else $error("serial clock pulsed while deselected");
    a_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock not low while deselected");
    a_sck_half_period: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("serial clock high phase not eight cycles");
    a_si_steady_high: assert property (sck && $past(sck) |-> $stable(si))
        else $error("serial input changed during clock high");
    a_so_steady_high: assert property (
        sck && $past(sck) && so_oe && $past(so_oe) |-> $stable(so))
        else $error("serial output changed during clock high");
    a_out_start_high: assert property ($rose(so_oe) |-> !cs_n && sck)
        else $error("output enabled outside last opcode clock high phase");
    a_release_prompt: assert property ($rose(cs_n) |-> ##2 !so_oe)
        else $error("output not released two cycles after deselect");
    a_idle_released: assert property (cs_n [*5] |-> !so_oe)
        else $error("output still driven after deselect");
    a_line_pulled_high: assert property (!so_oe |-> so_line)
        else $error("released line not high");
endmodule : pcr_properties
